// file: rtl/measurement_control_field_params.svh
// register offsets, field positions, reset values and timing counts of measurement control
// assumes inclusion by bare name from the design module
`ifndef MEASUREMENT_CONTROL_FIELD_PARAMS_SVH
`define MEASUREMENT_CONTROL_FIELD_PARAMS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ADDR_MODE 8'h08
`define ADDR_CONFIG 8'h09
`define ADDR_IRQ_FLAGS 8'h0a
`define ADDR_QUEUE_FLAGS 8'h0b

// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_COEF_READY 7
`define BIT_SENSOR_READY 6
`define BIT_TEMP_NEW 5
`define BIT_PRES_NEW 4
`define BIT_IRQ_POLARITY 7
`define BIT_IRQ_FULL_EN 6
`define BIT_IRQ_TEMP_EN 5
`define BIT_IRQ_PRES_EN 4
`define BIT_TEMP_SHIFT 3
`define BIT_PRES_SHIFT 2
`define BIT_QUEUE_EN 1
`define BIT_SPI_3WIRE 0
`define BIT_IRQ_FULL 2
`define BIT_IRQ_TEMP 1
`define BIT_IRQ_PRES 0
`define BIT_QUEUE_FULL 1
`define BIT_QUEUE_EMPTY 0

// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define RESET_CONFIG 8'h00
`define MODE_STANDBY 3'h0
`define MODE_CMD_PRES 3'h1
`define MODE_CMD_TEMP 3'h2
`define MODE_BG_PRES 3'h5
`define MODE_BG_TEMP 3'h6
`define MODE_BG_BOTH 3'h7

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_MHZ 25
`define MEAS_TIME_US 3600
`define MEAS_CYCLES (`MEAS_TIME_US * `CLK_MHZ)
`define COEF_LOAD_CYCLES 64
`define INIT_CYCLES 256

`endif

// file: rtl/measurement_control_field_pkg.sv
// types shared by the measurement control block
// assumes the params header is on the include path
package measurement_control_field_pkg;
	typedef enum logic [1:0] {ph_idle, ph_pres, ph_temp} phase_t;
	typedef struct packed {
		logic irq_polarity;
		logic irq_full_en;
		logic irq_temperature_en;
		logic irq_pressure_en;
		logic temp_shift;
		logic pres_shift;
		logic queue_en;
		logic spi_3wire;
	} config_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;
endpackage

// file: rtl/sensor_measurement_control.sv
// measurement mode, readiness, configuration and interrupt status of the sensor
// assumes a serial front end decodes I2C/SPI into one-cycle register strobes on clk
`timescale 1ns/1ps
`include "measurement_control_field_params.svh"

module sensor_measurement_control
	import measurement_control_field_pkg::*;
#(
	parameter int MEAS_CYCLES = `MEAS_CYCLES
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire reg_req_t reg_req,
	output logic [7:0] reg_rdata,
	input wire logic temp_result_read,
	input wire logic pres_result_read,
	input wire logic queue_full,
	input wire logic queue_empty,
	output logic meas_start_pres,
	output logic meas_start_temp,
	output logic meas_busy,
	output logic temp_shift,
	output logic pres_shift,
	output logic queue_en,
	output logic spi_3wire,
	output logic serial_out_pin_irq
);
	// counters below are sized for these ranges; anything else is refused here
	if (MEAS_CYCLES < 2)
		$error("MEAS_CYCLES too small");
	if (`INIT_CYCLES <= `COEF_LOAD_CYCLES)
		$error("self-init must end after the coefficient load");
	if (`INIT_CYCLES > 32'h0000_01ff)
		$error("self-init count exceeds the start-up counter");

	// ----------------------------------------
	// register access decode
	// ----------------------------------------
	function automatic logic hit(input reg_req_t r, input logic [7:0] a);
		hit = r.addr == a;
	endfunction

	logic wr_mode;
	logic wr_cfg;
	logic rd_irq;
	assign wr_mode = reg_req.wr && hit(reg_req, `ADDR_MODE);
	assign wr_cfg = reg_req.wr && hit(reg_req, `ADDR_CONFIG);
	assign rd_irq = reg_req.rd && hit(reg_req, `ADDR_IRQ_FLAGS);

	config_t cfg;
	logic [2:0] measurement_control_field;
	logic coefficients_loaded;
	logic sensor_ready;
	logic temperature_result_new;
	logic pressure_result_new;
	logic [2:0] interrupt_flags;
	logic [1:0] result_queue_flags;
	logic [8:0] start_count;
	logic full_d;
	logic [31:0] meas_count;
	phase_t phase;
	logic pres_done;
	logic temp_done;

	// ----------------------------------------
	// start-up: coefficient load, then self-init
	// ----------------------------------------
	// the counter freezes once ready so it never wraps back into the load window
	always_ff @(posedge clk)
	begin
		if (!resetn)
			start_count <= 9'h000;
		else if (!sensor_ready)
			start_count <= start_count + 9'h001;
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			coefficients_loaded <= 1'b0;
			sensor_ready <= 1'b0;
		end
		else
		begin
			if (start_count == 9'(`COEF_LOAD_CYCLES))
				coefficients_loaded <= 1'b1;
			if (start_count == 9'(`INIT_CYCLES))
				sensor_ready <= 1'b1;
		end
	end

	// ----------------------------------------
	// configuration register
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (!resetn)
			cfg <= config_t'(`RESET_CONFIG);
		else if (wr_cfg)
			cfg <= config_t'(reg_req.wdata);
	end

	// command codes clear themselves when their single conversion ends
	always_ff @(posedge clk)
	begin
		if (!resetn)
			measurement_control_field <= `MODE_STANDBY;
		else if (wr_mode)
			measurement_control_field <= reg_req.wdata[2:0];
		else if ((pres_done || temp_done) && !measurement_control_field[2])
			measurement_control_field <= `MODE_STANDBY;
	end

	// ----------------------------------------
	// measurement sequencer
	// ----------------------------------------
	// a new mode write aborts the running conversion so standby takes effect at once
	// code 111 runs pressure then temperature, with one idle cycle before the next pair
	assign pres_done = phase == ph_pres && meas_count == 32'(MEAS_CYCLES - 1);
	assign temp_done = phase == ph_temp && meas_count == 32'(MEAS_CYCLES - 1);

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			phase <= ph_idle;
			meas_count <= 32'h0000_0000;
			meas_start_pres <= 1'b0;
			meas_start_temp <= 1'b0;
		end
		else
		begin
			meas_start_pres <= 1'b0;
			meas_start_temp <= 1'b0;
			meas_count <= meas_count + 32'h0000_0001;
			if (wr_mode)
			begin
				phase <= ph_idle;
				meas_count <= 32'h0000_0000;
			end
			else
			begin
				case (phase)
				ph_idle:
				begin
					meas_count <= 32'h0000_0000;
					case (measurement_control_field)
					`MODE_CMD_PRES, `MODE_BG_PRES, `MODE_BG_BOTH:
					begin
						phase <= ph_pres;
						meas_start_pres <= 1'b1;
					end
					`MODE_CMD_TEMP, `MODE_BG_TEMP:
					begin
						phase <= ph_temp;
						meas_start_temp <= 1'b1;
					end
					default:
						phase <= ph_idle;
					endcase
				end
				ph_pres:
				begin
					if (pres_done)
					begin
						meas_count <= 32'h0000_0000;
						if (measurement_control_field == `MODE_BG_BOTH)
						begin
							phase <= ph_temp;
							meas_start_temp <= 1'b1;
						end
						else
							phase <= ph_idle;
					end
				end
				ph_temp:
				begin
					if (temp_done)
					begin
						meas_count <= 32'h0000_0000;
						phase <= ph_idle;
					end
				end
				default:
					phase <= ph_idle;
				endcase
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
			meas_busy <= 1'b0;
		else
			meas_busy <= phase != ph_idle && !wr_mode;
	end

	// ----------------------------------------
	// result readiness, set wins over clear
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			temperature_result_new <= 1'b0;
			pressure_result_new <= 1'b0;
		end
		else
		begin
			if (temp_done)
				temperature_result_new <= 1'b1;
			else if (temp_result_read)
				temperature_result_new <= 1'b0;
			if (pres_done)
				pressure_result_new <= 1'b1;
			else if (pres_result_read)
				pressure_result_new <= 1'b0;
		end
	end

	// ----------------------------------------
	// result queue status
	// ----------------------------------------
	// a disabled queue reads empty and never full, so enabling it while full fires a full edge
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			full_d <= 1'b0;
			result_queue_flags <= 2'h0;
		end
		else
		begin
			full_d <= queue_full && cfg.queue_en;
			result_queue_flags <= {queue_full && cfg.queue_en,
				queue_empty || !cfg.queue_en};
		end
	end

	// ----------------------------------------
	// interrupt flags, cleared on read
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (!resetn)
			interrupt_flags <= 3'h0;
		else
		begin
			// an event in the clearing cycle stays set
			// the full source fires on the rising edge of full, not while it stays full
			interrupt_flags[`BIT_IRQ_FULL] <= (cfg.irq_full_en && queue_full && cfg.queue_en
				&& !full_d) || (interrupt_flags[`BIT_IRQ_FULL] && !rd_irq);
			interrupt_flags[`BIT_IRQ_TEMP] <= (cfg.irq_temperature_en && temp_done)
				|| (interrupt_flags[`BIT_IRQ_TEMP] && !rd_irq);
			interrupt_flags[`BIT_IRQ_PRES] <= (cfg.irq_pressure_en && pres_done)
				|| (interrupt_flags[`BIT_IRQ_PRES] && !rd_irq);
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	logic irq_any;
	assign irq_any = |(interrupt_flags & {cfg.irq_full_en, cfg.irq_temperature_en,
		cfg.irq_pressure_en});

	// polarity is applied after the flags, so flipping it moves the pin at the next edge
	always_ff @(posedge clk)
	begin
		if (!resetn)
			serial_out_pin_irq <= 1'b1;
		else
			serial_out_pin_irq <= irq_any ~^ cfg.irq_polarity;
	end

	// copies lag the register by one cycle so every output stays a flip-flop
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			temp_shift <= 1'b0;
			pres_shift <= 1'b0;
			queue_en <= 1'b0;
			spi_3wire <= 1'b0;
		end
		else
		begin
			temp_shift <= cfg.temp_shift;
			pres_shift <= cfg.pres_shift;
			queue_en <= cfg.queue_en;
			spi_3wire <= cfg.spi_3wire;
		end
	end

	// ----------------------------------------
	// read data, registered
	// ----------------------------------------
	// unmapped addresses and reserved bits read as zero
	always_ff @(posedge clk)
	begin
		if (!resetn)
			reg_rdata <= 8'h00;
		else if (reg_req.rd)
		begin
			case (reg_req.addr)
			`ADDR_MODE:
				reg_rdata <= {coefficients_loaded, sensor_ready, temperature_result_new,
					pressure_result_new, 1'b0, measurement_control_field};
			`ADDR_CONFIG:
				reg_rdata <= cfg;
			`ADDR_IRQ_FLAGS:
				reg_rdata <= {5'h00, interrupt_flags};
			`ADDR_QUEUE_FLAGS:
				reg_rdata <= {6'h00, result_queue_flags};
			default:
				reg_rdata <= 8'h00;
			endcase
		end
	end
endmodule

// file: dv/sensor_measurement_control_monitor.sv
// port checker for measurement control
// assumes one clk domain with synchronous active-low reset
`timescale 1ns/1ps
module sensor_measurement_control_monitor
	import measurement_control_field_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire reg_req_t reg_req,
	input wire logic meas_start_pres,
	input wire logic meas_start_temp,
	input wire logic meas_busy,
	input wire logic temp_shift,
	input wire logic pres_shift,
	input wire logic queue_en,
	input wire logic spi_3wire,
	input wire logic serial_out_pin_irq
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!resetn);
	logic mode_wr;
	logic cfg_wr;
	logic go;
	logic [2:0] code;
	assign mode_wr = reg_req.wr && reg_req.addr == 8'h08;
	assign cfg_wr = reg_req.wr && reg_req.addr == 8'h09;
	assign go = meas_start_pres || meas_start_temp;
	assign code = reg_req.wdata[2:0];
	// ---
	// assertions
	// ---
	a_start_pulse: assert property (go |=> !go)
		else $error("start pulse too long");
	a_one_start: assert property (!(meas_start_pres && meas_start_temp))
		else $error("two starts at once");
	a_start_busy: assert property (go && !mode_wr |=> meas_busy)
		else $error("start without busy");
	a_cmd_pres: assert property (mode_wr && code == 3'h1 |-> ##2 meas_start_pres)
		else $error("no pressure start");
	a_cmd_temp: assert property (mode_wr && code == 3'h2 |-> ##2 meas_start_temp)
		else $error("no temperature start");
	a_unused_idle: assert property (mode_wr && code inside {3'h3, 3'h4} |=> (!go)[*4])
		else $error("unused code started");
	a_standby_stop: assert property (mode_wr && code == 3'h0 |-> ##2 (!meas_busy && !go)[*4])
		else $error("standby did not stop");
	a_cfg_copy: assert property (cfg_wr |-> ##2
		{temp_shift, pres_shift, queue_en, spi_3wire} == $past(reg_req.wdata[3:0], 2))
		else $error("config outputs wrong");
	a_irq_idle: assert property (cfg_wr && reg_req.wdata[6:4] == 3'h0 |-> ##2
		serial_out_pin_irq == !$past(reg_req.wdata[7], 2))
		else $error("idle pin level wrong");
	c_both: cover property (mode_wr && code == 3'h7);
	c_temp: cover property (meas_start_temp);
	c_cfg: cover property (cfg_wr);
endmodule

bind sensor_measurement_control sensor_measurement_control_monitor i_monitor (.clk(clk),
	.resetn(resetn), .reg_req(reg_req), .meas_start_pres(meas_start_pres),
	.meas_start_temp(meas_start_temp), .meas_busy(meas_busy), .temp_shift(temp_shift),
	.pres_shift(pres_shift), .queue_en(queue_en), .spi_3wire(spi_3wire),
	.serial_out_pin_irq(serial_out_pin_irq));

// file: dv/host_model.sv
// host model: register strobes and result-read pulses
// assumes its tasks are called after reset release
`timescale 1ns/1ps
module host_model
	import measurement_control_field_pkg::*;
(
	input wire logic clk,
	input wire logic [7:0] reg_rdata,
	output reg_req_t reg_req,
	output logic temp_result_read,
	output logic pres_result_read
);
	initial
	begin
		reg_req = '0;
		temp_result_read = 1'b0;
		pres_result_read = 1'b0;
	end
	// an edge passes between calls so strobes never merge
	task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk);
		reg_req <= {w, !w, a, d};
		@(posedge clk);
		reg_req <= '0;
		#1 q = reg_rdata;
	endtask
	task automatic result_read(input logic t);
		@(posedge clk);
		temp_result_read <= t;
		pres_result_read <= !t;
		@(posedge clk);
		temp_result_read <= 1'b0;
		pres_result_read <= 1'b0;
	endtask
	task automatic wait_ready();
		logic [7:0] s;
		s = 8'h00;
		repeat (400)
		begin
			if (!s[6])
			begin
				access(1'b0, 8'h08, 8'h00, s);
			end
		end
	endtask
	// without the shift, high oversampling overflows the result
	function automatic logic [7:0] shift_bits(input int t_os, input int p_os);
		return {4'h0, t_os > 8, p_os > 8, 2'b00};
	endfunction
endmodule

// file: dv/sensor_measurement_control_tb_top.sv
// self-checking bench for measurement control
// assumes host_model and the bound monitor are compiled alongside
`timescale 1ns/1ps
module sensor_measurement_control_tb_top
	import measurement_control_field_pkg::*;
;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic queue_full = 1'b0;
	logic queue_empty = 1'b1;
	reg_req_t reg_req;
	logic [7:0] reg_rdata;
	logic [7:0] q;
	logic temp_result_read, pres_result_read, meas_start_pres, meas_start_temp, meas_busy;
	logic temp_shift, pres_shift, queue_en, spi_3wire, serial_out_pin_irq;
	int err_count = 0;
	int n_checks = 0;
	int n_pres = 0;
	int n_temp = 0;
	int cycles = 0;
	sensor_measurement_control #(.MEAS_CYCLES(20)) i_dut (.clk(clk), .resetn(resetn),
		.reg_req(reg_req), .reg_rdata(reg_rdata), .temp_result_read(temp_result_read),
		.pres_result_read(pres_result_read), .queue_full(queue_full),
		.queue_empty(queue_empty), .meas_start_pres(meas_start_pres),
		.meas_start_temp(meas_start_temp), .meas_busy(meas_busy), .temp_shift(temp_shift),
		.pres_shift(pres_shift), .queue_en(queue_en), .spi_3wire(spi_3wire),
		.serial_out_pin_irq(serial_out_pin_irq));
	host_model i_host (.clk(clk), .reg_rdata(reg_rdata), .reg_req(reg_req),
		.temp_result_read(temp_result_read), .pres_result_read(pres_result_read));
	initial
	begin
		forever #20 clk = ~clk;
	end
	task automatic final_report();
		if (err_count == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cycles++;
		n_pres += meas_start_pres;
		n_temp += meas_start_temp;
		if (cycles == 6000)
		begin
			err_count++;
			final_report();
		end
	end
	task automatic check(input string s, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e)
		begin
			$display("unexpected %s expected %h seen %h", s, e, g);
			err_count++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_host.access(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string s);
		i_host.access(1'b0, a, 8'h00, q);
		check(s, e, q);
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic test_reset();
		rd(8'h08, 8'h00, "mode");
		rd(8'h09, 8'h00, "config");
		rd(8'h0a, 8'h00, "irq flags");
		rd(8'h0b, 8'h01, "queue flags");
		check("pin", 8'h01, serial_out_pin_irq);
		i_host.wait_ready();
		rd(8'h08, 8'hc0, "mode");
	endtask
	task automatic test_cmd();
		wr(8'h09, 8'h10);
		wr(8'h08, 8'h01);
		settle(5);
		check("busy", 8'h01, meas_busy);
		settle(25);
		rd(8'h08, 8'hd0, "mode");
		check("busy", 8'h00, meas_busy);
		check("pin", 8'h00, serial_out_pin_irq);
		rd(8'h0a, 8'h01, "irq flags");
		settle(1);
		check("pin", 8'h01, serial_out_pin_irq);
		rd(8'h0a, 8'h00, "irq flags");
		i_host.result_read(1'b0);
		rd(8'h08, 8'hc0, "mode");
		wr(8'h09, 8'ha0);
		wr(8'h08, 8'h02);
		check("pin", 8'h00, serial_out_pin_irq);
		settle(30);
		rd(8'h08, 8'he0, "mode");
		check("pin", 8'h01, serial_out_pin_irq);
		i_host.result_read(1'b1);
		rd(8'h08, 8'hc0, "mode");
		rd(8'h0a, 8'h02, "irq flags");
	endtask
	task automatic test_background();
		logic [2:0] codes [5] = '{3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
		int p;
		foreach (codes[i])
		begin
			n_pres = 0;
			n_temp = 0;
			wr(8'h08, {5'h00, codes[i]});
			settle(100);
			wr(8'h08, 8'h00);
			settle(1);
			p = n_pres + n_temp;
			check("pres run", 8'(codes[i][2] & codes[i][0]), 8'(n_pres > 0));
			check("temp run", 8'(codes[i][2] & codes[i][1]), 8'(n_temp > 0));
			settle(40);
			check("starts after stop", 8'(p), 8'(n_pres + n_temp));
			check("busy", 8'h00, meas_busy);
		end
		i_host.access(1'b0, 8'h0a, 8'h00, q);
	endtask
	task automatic test_config();
		wr(8'h09, 8'h80);
		settle(1);
		check("pin", 8'h00, serial_out_pin_irq);
		wr(8'h09, 8'h43 | i_host.shift_bits(16, 16));
		rd(8'h09, 8'h4f, "config");
		check("outputs", 8'h0f, {temp_shift, pres_shift, queue_en, spi_3wire});
		@(posedge clk);
		queue_full <= 1'b1;
		queue_empty <= 1'b0;
		rd(8'h0b, 8'h02, "queue flags");
		check("pin", 8'h00, serial_out_pin_irq);
		rd(8'h0a, 8'h04, "irq flags");
		@(posedge clk);
		queue_full <= 1'b0;
		wr(8'h09, 8'h0e);
		@(posedge clk);
		queue_full <= 1'b1;
		settle(3);
		check("pin", 8'h01, serial_out_pin_irq);
	endtask
	initial
	begin
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		test_reset();
		test_cmd();
		test_background();
		test_config();
		final_report();
	end
endmodule
